// ==== common/rps_pkg.sv ====
package rps_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_A_SET   = 8'h04;
   localparam logic [7:0] OFS_A_RST   = 8'h08;
   localparam logic [7:0] OFS_B_SET   = 8'h0C;
   localparam logic [7:0] OFS_B_RST   = 8'h10;
   localparam logic [7:0] OFS_OUT_CFG = 8'h14;
   localparam logic [7:0] OFS_IN_A    = 8'h18;
   localparam logic [7:0] OFS_IN_B    = 8'h1C;
   localparam logic [7:0] OFS_CAPTURE = 8'h20;
   localparam logic [7:0] OFS_STATUS  = 8'h24;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h28;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_RUN    = 0;
   localparam int CTRL_MODE   = 1;
   localparam int CTRL_FIFTY  = 3;
   localparam int CTRL_LOCK   = 4;
   localparam int CTRL_AUTO   = 5;
   localparam int CTRL_CLKSEL = 6;
   localparam int CFG_POL0    = 0;
   localparam int CFG_POL1    = 1;
   localparam int CFG_SEL_A   = 2;
   localparam int CFG_SEL_B   = 3;
   localparam int IN_EN       = 0;
   localparam int IN_FAULT    = 1;
   localparam int IN_SRC      = 2;
   localparam int IN_HIGH     = 3;
   localparam int ST_OVF      = 0;
   localparam int ST_FAULT    = 1;
   localparam int ST_CAP      = 2;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [6:0]  CTRL_RST = 7'h00;
   localparam logic [11:0] CMP_RST  = 12'h000;
   localparam logic [3:0]  CFG_RST  = 4'h0;
   localparam logic [3:0]  IN_RST   = 4'h0;
   localparam logic [2:0]  ST_RST   = 3'h0;
   // ----------------------------------------------------------------
   // modes and phases
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_ONE    = 2'h0;
   localparam logic [1:0] MODE_TWO    = 2'h1;
   localparam logic [1:0] MODE_FOUR   = 2'h2;
   localparam logic [1:0] MODE_CENTER = 2'h3;
   typedef enum logic [3:0] {
      PH_DT0 = 4'h1,
      PH_OT0 = 4'h2,
      PH_DT1 = 4'h4,
      PH_OT1 = 4'h8
   } rps_phase_t;
endpackage

// ==== rtl/rps_sync.sv ====
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module rps_sync
   import rps_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q      <= '0;
      end
      else
      begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < W; i++)
            if (s2_reg[i] == s3_reg[i])
               q[i] <= s3_reg[i];
      end
   end
endmodule

// ==== rtl/rps_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - four 12-bit set/reset compare values
// - capture counter on retrigger event
// - one irq: overflow, fault, capture
// - cycle is sub-cycle A then B
// - new values load at cycle top
// - centered mode counts up and down
// - four-ramp on/dead times, dead plus two
// - two-ramp times, dead-time set plus one
// - one-ramp times, outputs may overlap
// - period is sum of all times
// - fifty mode copies B into A
// - stopped immediate, running at cycle end
// - all values but B set update together; B set loads at every cycle end
// - write_triggered_update updates after B reset write
// - lock blocks update until cleared
// - write_triggered_update prevails over lock
// - lock covers A, B reset, config polarity bits
// - counter clock: I/O or PLL
// - per-part input: retrigger or fault
// - inputs from pins and comparator
// - ADC sync output
// - programmable output polarity
module rps_top
   import rps_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pll_clk_in,
   input  wire logic        sense_in_pin,
   input  wire logic        sense_in_a_pin,
   input  wire logic        sense_in_b_pin,
   input  wire logic        comp_in,
   output logic             wave_out_0,
   output logic             wave_out_1,
   output logic             stage_irq,
   output logic             adc_sync_out
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [12:0] phase_len(input logic [1:0] m, input rps_phase_t ph,
      input logic [11:0] sa, input logic [11:0] ra, input logic [11:0] sb,
      input logic [11:0] rb);
      logic [12:0] add;
      add = (m == MODE_FOUR) ? 13'h0002 : 13'h0001;
      case (ph)
         PH_DT0:  phase_len = {1'b0, sa} + add;
         PH_OT0:  phase_len = (m == MODE_FOUR) ? {1'b0, ra} : {1'b0, ra} - {1'b0, sa};
         PH_DT1:  phase_len = {1'b0, sb} + add;
         PH_OT1:  phase_len = (m == MODE_FOUR) ? {1'b0, rb} : {1'b0, rb} - {1'b0, sb};
         default: phase_len = 13'h0001;
      endcase
   endfunction

   function automatic logic in_src(input logic hi, input logic cmp, input logic own,
      input logic shared, input logic comp);
      in_src = hi ? shared : (cmp ? comp : own);
   endfunction

   // ----------------------------------------------------------------
   // synchronised pins
   // ----------------------------------------------------------------
   logic [4:0] pin_s;
   rps_sync #(.W(5)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({pll_clk_in, comp_in, sense_in_b_pin, sense_in_a_pin, sense_in_pin}),
      .q       (pin_s)
   );

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [6:0]  ctrl_reg;
   logic [11:0] wr_a_set_reg, wr_a_rst_reg, wr_b_set_reg, wr_b_rst_reg;
   logic [11:0] act_a_set_reg, act_a_rst_reg, act_b_set_reg, act_b_rst_reg;
   logic [3:0]  wr_cfg_reg, act_cfg_reg;
   logic [3:0]  in_a_reg, in_b_reg;
   logic [11:0] capture_reg;
   logic [2:0]  status_reg, irq_en_reg;
   logic        pend_reg, auto_eff_reg;
   logic        pll_prev_reg, act_a_prev_reg, act_b_prev_reg;
   logic [12:0] cnt_reg;
   logic        down_reg;
   rps_phase_t  phase_reg;

   logic        run, tick, multi, wr_en, eoc, last, load, rd_ok;
   logic        act_a, act_b, edge_a, edge_b, retrig_a, retrig_b, flt_a, flt_b, flt_ev;
   logic [1:0]  mode;
   logic [12:0] len;
   logic [11:0] rb13;
   logic        raw0, raw1;
   logic [31:0] rd_mux;

   assign run   = ctrl_reg[CTRL_RUN];
   assign mode  = ctrl_reg[CTRL_MODE +: 2];
   assign multi = (mode == MODE_TWO) || (mode == MODE_FOUR);
   assign wr_en = psel && penable && pready && pwrite;
   assign tick  = ctrl_reg[CTRL_CLKSEL] ? (pin_s[4] && !pll_prev_reg) : 1'b1;
   assign rb13  = act_b_rst_reg;

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         OFS_CTRL:    rd_mux[6:0]  = ctrl_reg;
         OFS_A_SET:   rd_mux[11:0] = wr_a_set_reg;
         OFS_A_RST:   rd_mux[11:0] = wr_a_rst_reg;
         OFS_B_SET:   rd_mux[11:0] = wr_b_set_reg;
         OFS_B_RST:   rd_mux[11:0] = wr_b_rst_reg;
         OFS_OUT_CFG: rd_mux[3:0]  = wr_cfg_reg;
         OFS_IN_A:    rd_mux[3:0]  = in_a_reg;
         OFS_IN_B:    rd_mux[3:0]  = in_b_reg;
         OFS_CAPTURE: rd_mux[11:0] = capture_reg;
         OFS_STATUS:  rd_mux[2:0]  = status_reg;
         OFS_IRQ_EN:  rd_mux[2:0]  = irq_en_reg;
         default:     rd_ok        = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !rd_ok;
         if (psel && penable && !pready)
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
   end

   // software-written copies
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg     <= CTRL_RST;
         wr_a_set_reg <= CMP_RST;
         wr_a_rst_reg <= CMP_RST;
         wr_b_set_reg <= CMP_RST;
         wr_b_rst_reg <= CMP_RST;
         wr_cfg_reg   <= CFG_RST;
         in_a_reg     <= IN_RST;
         in_b_reg     <= IN_RST;
         irq_en_reg   <= ST_RST;
      end
      else if (wr_en)
      begin
         case (paddr)
            OFS_CTRL:    ctrl_reg     <= pwdata[6:0];
            OFS_A_SET:   wr_a_set_reg <= pwdata[11:0];
            OFS_A_RST:   wr_a_rst_reg <= pwdata[11:0];
            OFS_B_SET:   wr_b_set_reg <= pwdata[11:0];
            OFS_B_RST:   wr_b_rst_reg <= pwdata[11:0];
            OFS_OUT_CFG: wr_cfg_reg   <= pwdata[3:0];
            OFS_IN_A:    in_a_reg     <= pwdata[3:0];
            OFS_IN_B:    in_b_reg     <= pwdata[3:0];
            OFS_IRQ_EN:  irq_en_reg   <= pwdata[2:0];
            default:     ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // input modules
   // ----------------------------------------------------------------
   assign act_a = in_src(wr_cfg_reg[CFG_SEL_A], in_a_reg[IN_SRC], pin_s[1], pin_s[0],
                         pin_s[3]) == in_a_reg[IN_HIGH];
   assign act_b = in_src(wr_cfg_reg[CFG_SEL_B], in_b_reg[IN_SRC], pin_s[2], pin_s[0],
                         pin_s[3]) == in_b_reg[IN_HIGH];
   assign edge_a = in_a_reg[IN_EN] && act_a && !act_a_prev_reg;
   assign edge_b = in_b_reg[IN_EN] && act_b && !act_b_prev_reg;
   // retrigger only inside own sub-cycle in multi-ramp modes
   assign retrig_a = run && tick && edge_a && !in_a_reg[IN_FAULT]
                     && (!multi || phase_reg == PH_DT0 || phase_reg == PH_OT0);
   assign retrig_b = run && tick && edge_b && !in_b_reg[IN_FAULT]
                     && (!multi || phase_reg == PH_DT1 || phase_reg == PH_OT1);
   assign flt_a  = in_a_reg[IN_EN] && in_a_reg[IN_FAULT] && act_a;
   assign flt_b  = in_b_reg[IN_EN] && in_b_reg[IN_FAULT] && act_b;
   assign flt_ev = (edge_a && in_a_reg[IN_FAULT]) || (edge_b && in_b_reg[IN_FAULT]);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pll_prev_reg   <= 1'b0;
         act_a_prev_reg <= 1'b0;
         act_b_prev_reg <= 1'b0;
      end
      else
      begin
         pll_prev_reg   <= pin_s[4];
         act_a_prev_reg <= act_a;
         act_b_prev_reg <= act_b;
      end
   end

   // ----------------------------------------------------------------
   // counter and phases
   // ----------------------------------------------------------------
   assign len  = phase_len(mode, phase_reg, act_a_set_reg, act_a_rst_reg,
                           act_b_set_reg, act_b_rst_reg);
   assign last = (cnt_reg + 13'h0001) >= len;

   // cycle ends when sub-cycle B ends
   always_comb
   begin
      case (mode)
         MODE_ONE:    eoc = run && tick && !retrig_a && !retrig_b && cnt_reg == {1'b0, rb13};
         MODE_CENTER: eoc = run && tick && down_reg && cnt_reg == 13'h0000;
         default:     eoc = run && tick && (retrig_b || (phase_reg == PH_OT1 && last));
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg   <= 13'h0000;
         phase_reg <= PH_DT0;
         down_reg  <= 1'b0;
      end
      else if (!run)
      begin
         cnt_reg   <= 13'h0000;
         phase_reg <= PH_DT0;
         down_reg  <= 1'b0;
      end
      else if (tick)
      begin
         case (mode)
            MODE_ONE:
               cnt_reg <= (retrig_a || retrig_b || eoc) ? 13'h0000 : cnt_reg + 13'h0001;
            MODE_CENTER:
            begin
               if (!down_reg)
               begin
                  down_reg <= cnt_reg >= {1'b0, rb13};
                  cnt_reg  <= (cnt_reg >= {1'b0, rb13}) ? cnt_reg - 13'h0001
                                                       : cnt_reg + 13'h0001;
               end
               else
               begin
                  down_reg <= cnt_reg != 13'h0000;
                  cnt_reg  <= (cnt_reg == 13'h0000) ? 13'h0001 : cnt_reg - 13'h0001;
               end
            end
            default:
            begin
               cnt_reg <= (retrig_a || eoc || last) ? 13'h0000 : cnt_reg + 13'h0001;
               if (retrig_a)
                  phase_reg <= PH_DT1;
               else if (eoc)
                  phase_reg <= PH_DT0;
               else if (last)
               begin
                  case (phase_reg)
                     PH_DT0:  phase_reg <= PH_OT0;
                     PH_OT0:  phase_reg <= PH_DT1;
                     PH_DT1:  phase_reg <= PH_OT1;
                     default: phase_reg <= PH_DT0;
                  endcase
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // synchronised update of waveform values
   // ----------------------------------------------------------------
   // write_triggered_update prevails over lock
   assign load = !run || (eoc && (auto_eff_reg ? pend_reg : !ctrl_reg[CTRL_LOCK]));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_a_set_reg <= CMP_RST;
         act_a_rst_reg <= CMP_RST;
         act_b_set_reg <= CMP_RST;
         act_b_rst_reg <= CMP_RST;
         act_cfg_reg   <= CFG_RST;
      end
      else
      begin
         if (!run || eoc)
            act_b_set_reg <= wr_b_set_reg;
         if (load)
         begin
            act_a_set_reg <= ctrl_reg[CTRL_FIFTY] ? wr_b_set_reg : wr_a_set_reg;
            act_a_rst_reg <= ctrl_reg[CTRL_FIFTY] ? wr_b_rst_reg : wr_a_rst_reg;
            act_b_rst_reg <= wr_b_rst_reg;
            act_cfg_reg   <= wr_cfg_reg;
         end
      end
   end

   // write_triggered_update arms at a cycle end; pending set wins over its clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         auto_eff_reg <= 1'b0;
         pend_reg     <= 1'b0;
      end
      else
      begin
         if (eoc)
            auto_eff_reg <= ctrl_reg[CTRL_AUTO];
         if (wr_en && paddr == OFS_B_RST)
            pend_reg <= 1'b1;
         else if (load)
            pend_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // capture, status, interrupt, outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         capture_reg <= CMP_RST;
         status_reg  <= ST_RST;
         stage_irq   <= 1'b0;
      end
      else
      begin
         if (retrig_a || retrig_b)
            capture_reg <= cnt_reg[11:0];
         for (int i = 0; i < 3; i++)
            if (wr_en && paddr == OFS_STATUS && pwdata[i])
               status_reg[i] <= 1'b0;
         if (eoc)
            status_reg[ST_OVF] <= 1'b1;
         if (flt_ev)
            status_reg[ST_FAULT] <= 1'b1;
         if (retrig_a || retrig_b)
            status_reg[ST_CAP] <= 1'b1;
         stage_irq <= |(status_reg & irq_en_reg);
      end
   end

   always_comb
   begin
      if (multi)
      begin
         raw0 = phase_reg == PH_OT0;
         raw1 = phase_reg == PH_OT1;
      end
      else
      begin
         raw0 = cnt_reg > {1'b0, act_a_set_reg} && cnt_reg <= {1'b0, act_a_rst_reg};
         raw1 = cnt_reg > {1'b0, act_b_set_reg} && cnt_reg <= {1'b0, act_b_rst_reg};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wave_out_0   <= 1'b0;
         wave_out_1   <= 1'b0;
         adc_sync_out <= 1'b0;
      end
      else
      begin
         wave_out_0   <= (run && raw0 && !flt_a) ^ act_cfg_reg[CFG_POL0];
         wave_out_1   <= (run && raw1 && !flt_b) ^ act_cfg_reg[CFG_POL1];
         adc_sync_out <= eoc;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !run |=> wave_out_0 == $past(act_cfg_reg[CFG_POL0]))
      else $error("output not inactive while stopped");
   a_cap_load: assert property (@(posedge pclk) disable iff (!presetn)
      (retrig_a || retrig_b) |=> capture_reg == $past(cnt_reg[11:0]) && status_reg[ST_CAP])
      else $error("capture not taken");
   a_ovf_sync: assert property (@(posedge pclk) disable iff (!presetn)
      eoc |=> adc_sync_out && status_reg[ST_OVF])
      else $error("cycle end not flagged");
   a_irq_out: assert property (@(posedge pclk) disable iff (!presetn)
      (|(status_reg & irq_en_reg)) |=> stage_irq)
      else $error("irq not raised");
   a_stop_load: assert property (@(posedge pclk) disable iff (!presetn)
      !run |=> act_b_rst_reg == $past(wr_b_rst_reg))
      else $error("stopped write not immediate");
   a_mid_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (run && !eoc) |=> $stable(act_a_rst_reg) && $stable(act_b_rst_reg))
      else $error("update inside cycle");
   a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (run && ctrl_reg[CTRL_LOCK] && !auto_eff_reg) |=> $stable(act_a_set_reg))
      else $error("update while locked");
   a_auto_load: assert property (@(posedge pclk) disable iff (!presetn)
      (eoc && auto_eff_reg && pend_reg && !(wr_en && paddr == OFS_B_RST))
      |=> act_b_rst_reg == $past(wr_b_rst_reg) && !pend_reg)
      else $error("write_triggered_update update missed");
   a_fifty_copy: assert property (@(posedge pclk) disable iff (!presetn)
      (load && ctrl_reg[CTRL_FIFTY]) |=> act_a_set_reg == $past(wr_b_set_reg))
      else $error("fifty copy missing");
endmodule

// ==== testbench/rps_far_side.sv ====
`timescale 1ns/1ps
// power stage and sense side: drives the fault line, counts shoot-through cycles
module rps_far_side (
   input  wire logic pclk,
   input  wire logic wave_out_0,
   input  wire logic wave_out_1,
   input  wire logic fault_req,
   input  wire logic watch,
   output logic      sense_in_pin,
   output logic      sense_in_a_pin,
   output logic      sense_in_b_pin,
   output logic      comp_in,
   output logic      pll_clk_in,
   output int        overlap_count
);
   initial pll_clk_in = 1'b0;
   initial overlap_count = 0;
   // pll source runs free and unrelated to pclk
   always #370 pll_clk_in = ~pll_clk_in;
   assign sense_in_a_pin = fault_req;
   assign sense_in_pin   = 1'b0;
   assign sense_in_b_pin = 1'b0;
   assign comp_in        = 1'b0;
   always @(posedge pclk)
   begin
      if (watch && wave_out_0 === 1'b1 && wave_out_1 === 1'b1)
      begin
         overlap_count <= overlap_count + 1;
      end
   end
endmodule

// ==== testbench/rps_top_test.sv ====
`timescale 1ns/1ps
module rps_top_test
   import rps_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        fault_req = 1'b0, watch = 1'b0, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, wave_out_0, wave_out_1, stage_irq, adc_sync_out;
   logic        pll_clk_in, sense_in_pin, sense_in_a_pin, sense_in_b_pin, comp_in;
   int          bad_count = 0, num_checks = 0, overlap_count, per, h0, h1;
   int          sa, ra, sb, rb;

   always #50 pclk = ~pclk;

   rps_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pll_clk_in(pll_clk_in), .sense_in_pin(sense_in_pin),
      .sense_in_a_pin(sense_in_a_pin), .sense_in_b_pin(sense_in_b_pin), .comp_in(comp_in),
      .wave_out_0(wave_out_0), .wave_out_1(wave_out_1), .stage_irq(stage_irq),
      .adc_sync_out(adc_sync_out));

   rps_far_side far (.pclk(pclk), .wave_out_0(wave_out_0), .wave_out_1(wave_out_1),
      .fault_req(fault_req), .watch(watch), .sense_in_pin(sense_in_pin),
      .sense_in_a_pin(sense_in_a_pin), .sense_in_b_pin(sense_in_b_pin), .comp_in(comp_in),
      .pll_clk_in(pll_clk_in), .overlap_count(overlap_count));

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // ----------------------------------------------------------------
   // apb master and waveform measurement
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         bad_count++;
         end_of_test();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("read data", rd & mask, e);
   endtask

   // one full cycle from one cycle-end pulse to the next
   task automatic measure();
      int n;
      n = 0;
      do begin @(posedge pclk); n++; end while (adc_sync_out !== 1'b1 && n < 3000);
      per = 0;
      h0  = 0;
      h1  = 0;
      do
      begin
         @(posedge pclk);
         per++;
         h0 += int'(wave_out_0 === 1'b1);
         h1 += int'(wave_out_1 === 1'b1);
      end while (adc_sync_out !== 1'b1 && per < 3000);
      if (n >= 3000 || per >= 3000)
      begin
         bad_count++;
         end_of_test();
      end
   endtask

   // stop, load all four compares, restart, skip the first three cycles
   task automatic run_cfg(input logic [31:0] ctl);
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_A_SET, 32'(sa));
      apb(1'b1, OFS_A_RST, 32'(ra));
      apb(1'b1, OFS_B_SET, 32'(sb));
      apb(1'b1, OFS_B_RST, 32'(rb));
      apb(1'b1, OFS_CTRL, ctl);
      measure();
      measure();
   endtask

   // k 0-3 four ramps, 4-7 two ramps, 8-9 one ramp, 10 centered
   function automatic int exp_per(input int k);
      if (k < 4)
         return ra + rb + sa + sb + 4;
      if (k < 8)
         return ra + rb + 2;
      if (k < 10)
         return (ra - sa) + (rb - sb) + (sa + 1) + (sb - ra);
      return 2 * rb;
   endfunction

   // centered: every count but top and bottom is passed twice
   function automatic int exp_on(input int k, input int s, input int r);
      if (k < 4)
         return r;
      if (k < 10)
         return r - s;
      return 2 * (r - s) - ((r == rb) ? 1 : 0);
   endfunction

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h58ED448E));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 11; i++) rchk(8'(4 * i), 32'hFFFFFFFF, 32'h0);
      apb(1'b0, 8'h2C, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      sa = $urandom_range(1, 4095);
      apb(1'b1, OFS_A_SET, 32'(sa));
      rchk(OFS_A_SET, 32'hFFFFFFFF, 32'(sa));
      apb(1'b1, OFS_CAPTURE, 32'hFFF);
      rchk(OFS_CAPTURE, 32'hFFFFFFFF, 32'h0);
      watch <= 1'b1;
      for (int k = 0; k < 11; k++)
      begin
         sa = (k == 0) ? 0 : $urandom_range(0, 6);
         sb = $urandom_range(0, 6);
         ra = (k < 4) ? $urandom_range(1, 9) : sa + $urandom_range(1, 9);
         rb = (k < 4) ? $urandom_range(1, 9) : sb + $urandom_range(1, 9);
         if (k >= 8)
         begin
            sa = $urandom_range(0, 3);
            ra = sa + $urandom_range(1, 3);
            sb = ra + $urandom_range(0, 3);
            rb = sb + $urandom_range(1, 6);
         end
         run_cfg((k < 4) ? 32'h05 : (k < 8) ? 32'h03 : (k < 10) ? 32'h01 : 32'h07);
         chk("period", 32'(per), 32'(exp_per(k)));
         chk("on time 0", 32'(h0), 32'(exp_on(k, sa, ra)));
         chk("on time 1", 32'(h1), 32'(exp_on(k, sb, rb)));
         if (k == 8)
            chk("one ramp period", 32'(per), 32'(rb + 1));
         if (k == 10)
            chk("centered period", 32'(per), 32'(2 * rb));
      end
      sa = 9;
      ra = 9;
      sb = 2;
      rb = 4;
      run_cfg(32'h0D);
      chk("fifty on time 0", 32'(h0), 32'h4);
      sa = 1;
      ra = 3;
      sb = 1;
      rb = 3;
      run_cfg(32'h15);
      apb(1'b1, OFS_A_RST, 32'h6);
      measure();
      measure();
      chk("locked on time 0", 32'(h0), 32'h3);
      apb(1'b1, OFS_CTRL, 32'h05);
      measure();
      measure();
      chk("released on time 0", 32'(h0), 32'h6);
      chk("released period", 32'(per), 32'hF);
      apb(1'b1, OFS_CTRL, 32'h35);
      measure();
      apb(1'b1, OFS_A_RST, 32'h2);
      measure();
      measure();
      chk("auto held on time 0", 32'(h0), 32'h6);
      apb(1'b1, OFS_B_RST, 32'h3);
      measure();
      measure();
      chk("auto on time 0", 32'(h0), 32'h2);
      // eleven counter ticks on a 740 ns source clock
      apb(1'b1, OFS_CTRL, 32'h45);
      measure();
      measure();
      chk("pll period", 32'(per >= 80 && per <= 83), 32'h1);
      chk("no overlap", 32'(overlap_count), 32'h0);
      watch <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_OUT_CFG, 32'h3);
      repeat (4) @(posedge pclk);
      chk("inactive high 0", 32'(wave_out_0), 32'h1);
      chk("inactive high 1", 32'(wave_out_1), 32'h1);
      apb(1'b1, OFS_OUT_CFG, 32'h0);
      apb(1'b1, OFS_IN_A, 32'hB);
      apb(1'b1, OFS_IRQ_EN, 32'h2);
      fault_req <= 1'b1;
      run_cfg(32'h05);
      chk("fault on time 0", 32'(h0), 32'h0);
      chk("irq raised", 32'(stage_irq), 32'h1);
      rchk(OFS_STATUS, 32'h2, 32'h2);
      apb(1'b1, OFS_IRQ_EN, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'(stage_irq), 32'h0);
      fault_req <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b1, OFS_IRQ_EN, 32'h2);
      apb(1'b1, OFS_STATUS, 32'h7);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'(stage_irq), 32'h0);
      // retrigger edge lands inside on-time 0 of the fresh cycle
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_IN_A, 32'h9);
      apb(1'b1, OFS_CTRL, 32'h05);
      fault_req <= 1'b1;
      repeat (12) @(posedge pclk);
      rchk(OFS_STATUS, 32'h4, 32'h4);
      end_of_test();
   end
endmodule
